// *** core/hs_gate_pkg.sv ***
// Constants and carrier types for the high-side gate enable logic.
// Assumes one 250 MHz clock and a word-wide register port from the SPI core.
package hs_gate_pkg;

   ////////////////////////////////////////////////////////////////////////
   // Geometry and timing
   localparam int NUM_CHANNELS = 5;
   localparam int SLEW_WIDTH = 2;
   localparam int REG_ADDR_WIDTH = 10;
   localparam int REG_DATA_WIDTH = 16;
   localparam int CLK_FREQ_MHZ = 250;
   localparam int DIGITAL_OUTPUT_READY_TIME_US = 300;
   // Longest time; 300 us at 250 MHz gives exactly 75000 cycles, with no rounding
   localparam int READY_CYCLES =
      DIGITAL_OUTPUT_READY_TIME_US * CLK_FREQ_MHZ;

   ////////////////////////////////////////////////////////////////////////
   // Register offsets
   localparam logic [9:0] DRIVER_CONFIGURATION_OFS = 10'h1C5;
   localparam logic [9:0] BACKUP_CLOCK_STATE_OFS = 10'h1C7;
   localparam logic [9:0] SLEW_SELECT_OFS = 10'h1C8;
   localparam logic [9:0] DRIVER_FAULT_STATE_OFS = 10'h1D2;

   // driver_configuration fields
   localparam int CFG_OVER_TEMP_IRQ_EN_BIT = 0;
   localparam int CFG_BOOST_UV_IRQ_EN_BIT = 1;
   localparam int CFG_CH5_OVERRIDE_BIT = 2;
   localparam int CFG_BOOST_UV_SHUTDOWN_EN_BIT = 3;
   localparam int CFG_BOOST_UV_MONITOR_EN_BIT = 4;
   localparam int CFG_WIDTH = 5;
   localparam logic [4:0] CFG_RESET = 5'h00;

   // backup_clock_state fields
   localparam int CLK_LOSS_SHUTDOWN_EN_BIT = 0;
   localparam int CLK_OK_BIT = 1;
   localparam logic CLK_LOSS_SHUTDOWN_RESET = 1'b0;

   // Slew select: two bits per channel, channel 0 lowest
   localparam logic [9:0] SLEW_RESET = 10'h000;

   // driver_fault_state fields
   localparam int ST_OVER_TEMP_BIT = 0;
   localparam int ST_DRIVE_ENABLE_BIT = 1;
   localparam int ST_BOOST_UV_BIT = 2;
   localparam int ST_GATE_UV_BIT = 3;
   localparam int ST_LOGIC_UV_BIT = 4;
   localparam int ST_LOGIC_OV_BIT = 5;
   localparam int ST_IRQ_PENDING_BIT = 6;

   ////////////////////////////////////////////////////////////////////////
   // Carriers
   typedef struct packed {
      logic drive_enable;
      logic override_en;
      logic gate_supply_undervoltage;
      logic logic_supply_undervoltage;
      logic boost_block;
      logic clock_block;
      logic logic_supply_overvoltage;
      logic in_reset;
   } gate_qual_t;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [REG_ADDR_WIDTH-1:0] addr;
      logic [REG_DATA_WIDTH-1:0] wdata;
   } reg_req_t;

endpackage

// *** core/gate_channel.sv ***
// One high-side channel: qualifies the sequencer request with faults.
// Assumes all qualifiers are already synchronous to the system clock.
module gate_channel
   import hs_gate_pkg::*;
#(
   parameter bit OVERRIDE_CAPABLE = 1'b0
) (
   input wire gate_qual_t qual,
   input wire logic request,
   output logic command,
   output logic pull_up,
   output logic pull_down
);

   logic enable_ok;

   // Only the override-capable channel may ignore the enable pin
   assign enable_ok = qual.drive_enable |
                      (OVERRIDE_CAPABLE & qual.override_en);

   // Pure combinational path, no register in the way
   assign command = enable_ok & request &
                    ~qual.gate_supply_undervoltage &
                    ~qual.logic_supply_undervoltage &
                    ~qual.boost_block &
                    ~qual.clock_block &
                    ~qual.logic_supply_overvoltage &
                    ~qual.in_reset;

   // Low side use changes only the wiring outside
   assign pull_up = command;
   assign pull_down = ~command;

endmodule

// *** core/ready_timer.sv ***
// Counts from reset release until the digital outputs may be trusted.
// Assumes reset is asynchronous and active high.
module ready_timer #(
   parameter int CYCLES = 75000
) (
   input wire logic ref_clk,
   input wire logic rst,
   output logic ready_q
);

   localparam int CW = (CYCLES < 2) ? 1 : $clog2(CYCLES + 1);

   logic [CW-1:0] count_q;

   generate
      if (CYCLES < 1) begin : g_bad
         $error("ready_timer: CYCLES must be at least one");
      end
   endgenerate

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         count_q <= '0;
      end else if (!ready_q) begin
         count_q <= count_q + CW'(1);
      end
   end

   // Ready at exactly CYCLES edges after release
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         ready_q <= 1'b0;
      end else if (count_q == CW'(CYCLES - 1)) begin
         ready_q <= 1'b1;
      end
   end

endmodule

// *** core/highside_gate_enable_logic.sv ***
// High-side gate enable logic: fault gating for five pre-drivers,
// its configuration and status registers and its interrupt request.
// Assumes the SPI core presents single-cycle register strobes and that
// all monitor flags and the enable pin are synchronous to ref_clk.
//
// Summary of operation
// - Overtemperature from the monitor shows as a status flag.
// - Overtemperature with its enable set raises the interrupt request.
// - Enable pin low turns every pre-driver off except channel five with override set; registers keep working.
// - Enable pin level is readable in the fault state register.
// - Logic supply overvoltage forces all pre-drivers off while present.
// - Digital outputs are ready within 300 us of reset release.
// - During reset every gate is pulled down to its source.
// - Five channels, each with a two-bit slew select set over SPI.
// - Override bit lets channel five ignore the enable pin.
// - Gate or logic supply undervoltage forces gate commands off.
// - Boost undervoltage forces commands off when shutdown is enabled.
// - Clock loss forces gates off when enabled; enable resets off.
// - Command high only with enable or ch5 override, no gate or logic undervoltage, clock ok when clock loss is enabled, request.
// - Low command pulls the gate down, high command pulls it up.
// - Channel requests come from the sequencing cores.
// - Any channel may serve as a low-side driver, same gating.
// - Boost undervoltage flag is active high, gated by monitor enable.
module highside_gate_enable_logic
   import hs_gate_pkg::*;
#(
   parameter int NCH = NUM_CHANNELS,
   parameter int READY_CYC = READY_CYCLES
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic [NCH-1:0] channel_request,
   input wire logic drive_enable,
   input wire logic gate_supply_undervoltage,
   input wire logic logic_supply_undervoltage,
   input wire logic logic_supply_overvoltage,
   input wire logic boost_below_threshold,
   input wire logic clock_ok,
   input wire logic over_temp,
   input wire reg_req_t reg_req,
   output logic [REG_DATA_WIDTH-1:0] reg_rdata_q,
   output logic reg_rvalid_q,
   output logic irq_request_q,
   output logic digital_ready_q,
   output logic [NCH*SLEW_WIDTH-1:0] slew_select_q,
   output logic [NCH-1:0] gate_command,
   output logic [NCH-1:0] gate_pull_up,
   output logic [NCH-1:0] gate_pull_down
);

   ////////////////////////////////////////////////////////////////////////
   // Elaboration checks

   generate
      if (NCH != NUM_CHANNELS) begin : g_bad_nch
         $error("highside_gate_enable_logic: only five channels");
      end
      if (READY_CYC < 1) begin : g_bad_ready
         $error("highside_gate_enable_logic: READY_CYC below one");
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // Declarations

   logic [CFG_WIDTH-1:0] config_q;
   logic clock_loss_en_q;
   logic [NCH*SLEW_WIDTH-1:0] slew_d;
   logic over_temp_seen_q;
   logic boost_uv_seen_q;
   logic irq_pending_q;
   logic boost_undervoltage;
   logic over_temp_rise;
   logic boost_uv_rise;
   logic irq_event;
   logic irq_clear;
   logic wr_ok;
   logic rd_ok;
   logic hit_cfg;
   logic hit_clk;
   logic hit_slew;
   logic hit_status;
   logic [REG_DATA_WIDTH-1:0] status_word;
   logic [REG_DATA_WIDTH-1:0] read_mux;
   logic ot_irq_en;
   logic boost_irq_en;
   logic ch5_override_en;
   logic boost_shutdown_en;
   logic boost_monitor_en;
   logic wr_cfg;
   logic wr_clk;
   logic wr_slew;
   logic boost_block;
   logic clock_block;
   logic ot_irq_event;
   logic boost_irq_event;
   logic [REG_DATA_WIDTH-1:0] cfg_word;
   logic [REG_DATA_WIDTH-1:0] clk_word;
   logic [REG_DATA_WIDTH-1:0] slew_word;
   gate_qual_t qual;

   ////////////////////////////////////////////////////////////////////////
   // Ready timer

   ready_timer #(
      .CYCLES(READY_CYC)
   ) u_ready (
      .ref_clk(ref_clk),
      .rst(rst),
      .ready_q(digital_ready_q)
   );

   ////////////////////////////////////////////////////////////////////////
   // Register decode
   // Accesses before ready are dropped so the host sees a clean start

   assign wr_ok = reg_req.wr & digital_ready_q;
   assign rd_ok = reg_req.rd & digital_ready_q & ~reg_req.wr;

   assign hit_cfg = (reg_req.addr == DRIVER_CONFIGURATION_OFS);
   assign hit_clk = (reg_req.addr == BACKUP_CLOCK_STATE_OFS);
   assign hit_slew = (reg_req.addr == SLEW_SELECT_OFS);
   assign hit_status = (reg_req.addr == DRIVER_FAULT_STATE_OFS);

   assign wr_cfg = wr_ok & hit_cfg;
   assign wr_clk = wr_ok & hit_clk;
   assign wr_slew = wr_ok & hit_slew;

   ////////////////////////////////////////////////////////////////////////
   // Driver configuration

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         config_q <= CFG_RESET;
      end else if (wr_cfg) begin
         config_q <= reg_req.wdata[CFG_WIDTH-1:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Configuration fields by name
   // Named once here so the gating below reads like the rules

   assign ot_irq_en = config_q[CFG_OVER_TEMP_IRQ_EN_BIT];
   assign boost_irq_en = config_q[CFG_BOOST_UV_IRQ_EN_BIT];
   assign ch5_override_en = config_q[CFG_CH5_OVERRIDE_BIT];
   assign boost_shutdown_en = config_q[CFG_BOOST_UV_SHUTDOWN_EN_BIT];
   assign boost_monitor_en = config_q[CFG_BOOST_UV_MONITOR_EN_BIT];

   ////////////////////////////////////////////////////////////////////////
   // Clock loss shutdown enable, off after reset

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         clock_loss_en_q <= CLK_LOSS_SHUTDOWN_RESET;
      end else if (wr_clk) begin
         clock_loss_en_q <= reg_req.wdata[CLK_LOSS_SHUTDOWN_EN_BIT];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Slew select per channel

   always_comb begin
      slew_d = slew_select_q;
      if (wr_slew) begin
         slew_d = reg_req.wdata[NCH*SLEW_WIDTH-1:0];
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         slew_select_q <= SLEW_RESET;
      end else begin
         slew_select_q <= slew_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Boost undervoltage flag
   // Monitor enable masks the comparator; shutdown enable is separate

   assign boost_undervoltage = boost_below_threshold &
                               boost_monitor_en;

   ////////////////////////////////////////////////////////////////////////
   // Shutdown causes that depend on an enable
   // Kept combinational so a fault cuts the gate in its own cycle

   assign boost_block = boost_undervoltage & boost_shutdown_en;
   assign clock_block = clock_loss_en_q & ~clock_ok;

   ////////////////////////////////////////////////////////////////////////
   // Interrupt sources

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         over_temp_seen_q <= 1'b0;
      end else begin
         over_temp_seen_q <= over_temp;
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         boost_uv_seen_q <= 1'b0;
      end else begin
         boost_uv_seen_q <= boost_undervoltage;
      end
   end

   // Edges only, so a standing fault does not refire after a clear
   assign over_temp_rise = over_temp & ~over_temp_seen_q;
   assign boost_uv_rise = boost_undervoltage & ~boost_uv_seen_q;

   assign ot_irq_event = over_temp_rise & ot_irq_en;
   assign boost_irq_event = boost_uv_rise & boost_irq_en;
   assign irq_event = ot_irq_event | boost_irq_event;

   // Reading the fault state acknowledges the request
   assign irq_clear = rd_ok & hit_status;

   // A new event in the clearing cycle wins
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         irq_pending_q <= 1'b0;
      end else if (irq_event) begin
         irq_pending_q <= 1'b1;
      end else if (irq_clear) begin
         irq_pending_q <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         irq_request_q <= 1'b0;
      end else begin
         irq_request_q <= (irq_pending_q & ~irq_clear) | irq_event;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Status word

   always_comb begin
      status_word = '0;
      status_word[ST_OVER_TEMP_BIT] = over_temp;
      status_word[ST_DRIVE_ENABLE_BIT] = drive_enable;
      status_word[ST_BOOST_UV_BIT] = boost_undervoltage;
      status_word[ST_GATE_UV_BIT] = gate_supply_undervoltage;
      status_word[ST_LOGIC_UV_BIT] = logic_supply_undervoltage;
      status_word[ST_LOGIC_OV_BIT] = logic_supply_overvoltage;
      status_word[ST_IRQ_PENDING_BIT] = irq_pending_q;
   end

   ////////////////////////////////////////////////////////////////////////
   // Register words, unused bits read zero
   // One word per register keeps the read select flat

   always_comb begin
      cfg_word = '0;
      cfg_word[CFG_WIDTH-1:0] = config_q;
   end

   always_comb begin
      clk_word = '0;
      clk_word[CLK_LOSS_SHUTDOWN_EN_BIT] = clock_loss_en_q;
      clk_word[CLK_OK_BIT] = clock_ok;
   end

   always_comb begin
      slew_word = '0;
      slew_word[NCH*SLEW_WIDTH-1:0] = slew_select_q;
   end

   ////////////////////////////////////////////////////////////////////////
   // Read path

   always_comb begin
      read_mux = '0;
      if (hit_cfg) begin
         read_mux = cfg_word;
      end else if (hit_clk) begin
         read_mux = clk_word;
      end else if (hit_slew) begin
         read_mux = slew_word;
      end else if (hit_status) begin
         read_mux = status_word;
      end
   end

   // Data holds until the next read; unmapped reads return zero
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         reg_rdata_q <= '0;
      end else if (rd_ok) begin
         reg_rdata_q <= read_mux;
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         reg_rvalid_q <= 1'b0;
      end else begin
         reg_rvalid_q <= rd_ok;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Gate qualifiers
   // Kept off the flip-flops on purpose: a fault must cut the gate at once

   always_comb begin
      qual = '0;
      qual.drive_enable = drive_enable;
      qual.override_en = ch5_override_en;
      qual.gate_supply_undervoltage = gate_supply_undervoltage;
      qual.logic_supply_undervoltage = logic_supply_undervoltage;
      qual.boost_block = boost_block;
      qual.clock_block = clock_block;
      qual.logic_supply_overvoltage = logic_supply_overvoltage;
      qual.in_reset = rst;
   end

   ////////////////////////////////////////////////////////////////////////
   // Channels

   generate
      for (genvar ch = 0; ch < NCH; ch++) begin : g_ch
         gate_channel #(
            .OVERRIDE_CAPABLE(ch == NCH - 1)
         ) u_ch (
            .qual(qual),
            .request(channel_request[ch]),
            .command(gate_command[ch]),
            .pull_up(gate_pull_up[ch]),
            .pull_down(gate_pull_down[ch])
         );
      end
   endgenerate

endmodule

// *** tb/gate_enable_monitor.sv ***
// Port-level checker for the high-side gate enable logic.
// Assumes it is bound to the top module and sees only its ports.
module gate_enable_monitor
   import hs_gate_pkg::*;
#(
   parameter int NCH = NUM_CHANNELS,
   parameter int READY_CYC = READY_CYCLES
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic [NCH-1:0] channel_request,
   input wire logic drive_enable,
   input wire logic gate_supply_undervoltage,
   input wire logic logic_supply_undervoltage,
   input wire logic logic_supply_overvoltage,
   input wire logic boost_below_threshold,
   input wire logic over_temp,
   input wire reg_req_t reg_req,
   input wire logic [REG_DATA_WIDTH-1:0] reg_rdata_q,
   input wire logic reg_rvalid_q,
   input wire logic irq_request_q,
   input wire logic digital_ready_q,
   input wire logic [NCH-1:0] gate_command,
   input wire logic [NCH-1:0] gate_pull_up,
   input wire logic [NCH-1:0] gate_pull_down
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);

   ////////////////////////////////////////////////////////////////////////
   // Cycles since reset release, saturating at the ready count
   int cnt_q;
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) cnt_q <= 0;
      else if (cnt_q < READY_CYC) cnt_q <= cnt_q + 1;
   end

   ////////////////////////////////////////////////////////////////////////
   ready_time_a: assert property (
      digital_ready_q == (cnt_q >= READY_CYC)) else $error("ready time off");
   early_refuse_a: assert property (
      !digital_ready_q |=> !reg_rvalid_q) else $error("read before ready");
   read_answer_a: assert property (
      reg_req.rd && !reg_req.wr && digital_ready_q |=> reg_rvalid_q)
      else $error("read not answered");
   status_bits_a: assert property (
      reg_req.rd && !reg_req.wr && digital_ready_q &&
      reg_req.addr == DRIVER_FAULT_STATE_OFS |=>
      reg_rdata_q[ST_OVER_TEMP_BIT] == $past(over_temp) &&
      reg_rdata_q[ST_DRIVE_ENABLE_BIT] == $past(drive_enable))
      else $error("status bits wrong");
   irq_cause_a: assert property (
      $rose(irq_request_q) |-> $past(over_temp) || $past(boost_below_threshold))
      else $error("irq without cause");
   enable_cut_a: assert property (
      !drive_enable |-> gate_command[NCH-2:0] == '0)
      else $error("gate on with enable low");
   uv_cut_a: assert property (
      gate_supply_undervoltage || logic_supply_undervoltage |->
      gate_command == '0) else $error("gate on in undervoltage");
   ov_cut_a: assert property (
      logic_supply_overvoltage |-> gate_command == '0)
      else $error("gate on in overvoltage");
   request_gate_a: assert property (
      (gate_command & ~channel_request) == '0)
      else $error("gate on without request");
   pull_pair_a: assert property (
      gate_pull_up == gate_command && gate_pull_down == ~gate_command)
      else $error("pull pair mismatch");
endmodule

bind highside_gate_enable_logic gate_enable_monitor #(
   .NCH(NCH),
   .READY_CYC(READY_CYC)
) mon (
   .ref_clk(ref_clk),
   .rst(rst),
   .channel_request(channel_request),
   .drive_enable(drive_enable),
   .gate_supply_undervoltage(gate_supply_undervoltage),
   .logic_supply_undervoltage(logic_supply_undervoltage),
   .logic_supply_overvoltage(logic_supply_overvoltage),
   .boost_below_threshold(boost_below_threshold),
   .over_temp(over_temp),
   .reg_req(reg_req),
   .reg_rdata_q(reg_rdata_q),
   .reg_rvalid_q(reg_rvalid_q),
   .irq_request_q(irq_request_q),
   .digital_ready_q(digital_ready_q),
   .gate_command(gate_command),
   .gate_pull_up(gate_pull_up),
   .gate_pull_down(gate_pull_down)
);

// *** tb/gate_load_model.sv ***
// External transistor gates seen from the pre-driver pins.
// Assumes the design drives each gate through a pull-up and pull-down pair.
module gate_load_model (
   input wire logic [4:0] pull_up,
   input wire logic [4:0] pull_down,
   output logic [4:0] gate_level
);
   timeunit 1ns;
   timeprecision 100ps;
   // Fight or float shows as unknown so a bad pair never looks clean
   always_comb begin
      for (int i = 0; i < 5; i++) begin
         if (pull_up[i] && !pull_down[i]) gate_level[i] = 1'b1;
         else if (pull_down[i] && !pull_up[i]) gate_level[i] = 1'b0;
         else gate_level[i] = 1'bx;
      end
   end
endmodule

// *** tb/testbench.sv ***
// Self-checking bench for the high-side gate enable logic.
// Assumes a shortened ready count and a behavioural gate load.
module testbench
   import hs_gate_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int RC = 8;
   logic ref_clk, rst, de, guv, luv, lov, bst, ck, ot;
   logic [4:0] req, cmd, pu, pd, lvl;
   reg_req_t rq;
   logic [15:0] rdata, got;
   logic rvalid, irq, ready;
   logic [9:0] slew;
   int n_errors, checks, n;

   highside_gate_enable_logic #(.NCH(5), .READY_CYC(RC)) dut (
      .ref_clk(ref_clk), .rst(rst), .channel_request(req),
      .drive_enable(de), .gate_supply_undervoltage(guv),
      .logic_supply_undervoltage(luv), .logic_supply_overvoltage(lov),
      .boost_below_threshold(bst), .clock_ok(ck), .over_temp(ot),
      .reg_req(rq), .reg_rdata_q(rdata), .reg_rvalid_q(rvalid),
      .irq_request_q(irq), .digital_ready_q(ready),
      .slew_select_q(slew), .gate_command(cmd), .gate_pull_up(pu),
      .gate_pull_down(pd));
   gate_load_model load (.pull_up(pu), .pull_down(pd), .gate_level(lvl));

   initial begin
      ref_clk = 1'b0;
      forever #2 ref_clk = ~ref_clk;
   end

   ////////////////////////////////////////////////////////////////////////
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   task automatic check(input string what, input logic [15:0] exp,
                        input logic [15:0] seen);
      checks++;
      if (seen !== exp) begin
         $display("wrong value %s expected %h seen %h", what, exp, seen);
         n_errors++;
      end
   endtask

   task automatic reg_write(input logic [9:0] a, input logic [15:0] d);
      @(posedge ref_clk);
      rq.wr <= 1'b1;
      rq.addr <= a;
      rq.wdata <= d;
      @(posedge ref_clk);
      rq.wr <= 1'b0;
   endtask

   // Bounded wait for the one-cycle answer pulse
   task automatic reg_read(input logic [9:0] a, output logic [15:0] d);
      @(posedge ref_clk);
      rq.rd <= 1'b1;
      rq.addr <= a;
      @(posedge ref_clk);
      rq.rd <= 1'b0;
      for (int i = 0; i < 4; i++) begin
         #1;
         if (rvalid === 1'b1) begin
            d = rdata;
            return;
         end
         @(posedge ref_clk);
      end
      n_errors++;
      give_verdict();
   endtask

   task automatic read_chk(input logic [9:0] a, input logic [15:0] exp);
      reg_read(a, got);
      check("register", exp, got);
   endtask

   // f holds enable, gate uv, logic uv, logic ov, boost, clock ok
   task automatic gate_case(input logic [5:0] f, input logic [4:0] r,
                            input logic [4:0] exp);
      @(posedge ref_clk);
      {de, guv, luv, lov, bst, ck} <= f;
      req <= r;
      @(negedge ref_clk);
      check("gate command", {11'h0, exp}, {11'h0, cmd});
      check("gate level", {11'h0, exp}, {11'h0, lvl});
   endtask

   ////////////////////////////////////////////////////////////////////////
   initial begin
      n_errors = 0;
      checks = 0;
      rst = 1'b1;
      req = 5'h1F;
      {de, guv, luv, lov, bst, ck, ot} = 7'h62;
      rq = '0;
      repeat (3) @(negedge ref_clk);
      check("reset pull down", 16'h001F, {11'h0, pd});
      repeat (2) @(posedge ref_clk);
      rst <= 1'b0;
      n = 0;
      while (n < 50 && ready !== 1'b1) begin
         @(posedge ref_clk);
         #1 n++;
      end
      check("ready cycles", RC[15:0], n[15:0]);
      if (ready !== 1'b1) begin
         give_verdict();
      end
      $display("test reset done");

      read_chk(DRIVER_CONFIGURATION_OFS, 16'h0000);
      read_chk(BACKUP_CLOCK_STATE_OFS, 16'h0002);
      read_chk(SLEW_SELECT_OFS, 16'h0000);
      read_chk(10'h3FF, 16'h0000);
      reg_write(SLEW_SELECT_OFS, 16'h02E4);
      @(negedge ref_clk);
      check("slew select", 16'h02E4, {6'h0, slew});
      read_chk(SLEW_SELECT_OFS, 16'h02E4);
      $display("test registers done");

      gate_case(6'b100001, 5'h1F, 5'h1F);
      gate_case(6'b000001, 5'h1F, 5'h00);
      gate_case(6'b110001, 5'h1F, 5'h00);
      gate_case(6'b101001, 5'h1F, 5'h00);
      gate_case(6'b100101, 5'h1F, 5'h00);
      gate_case(6'b100011, 5'h1F, 5'h1F);
      gate_case(6'b100000, 5'h1F, 5'h1F);
      gate_case(6'b100001, 5'h0A, 5'h0A);
      reg_write(BACKUP_CLOCK_STATE_OFS, 16'h0001);
      gate_case(6'b100000, 5'h15, 5'h00);
      gate_case(6'b100001, 5'h15, 5'h15);
      reg_write(DRIVER_CONFIGURATION_OFS, 16'h0018);
      gate_case(6'b100011, 5'h1F, 5'h00);
      reg_write(DRIVER_CONFIGURATION_OFS, 16'h0004);
      gate_case(6'b000001, 5'h1F, 5'h10);
      $display("test gating done");

      reg_write(DRIVER_CONFIGURATION_OFS, 16'h0001);
      gate_case(6'b100001, 5'h1F, 5'h1F);
      @(posedge ref_clk);
      ot <= 1'b1;
      repeat (2) @(negedge ref_clk);
      check("irq raised", 16'h0001, {15'h0, irq});
      read_chk(DRIVER_FAULT_STATE_OFS, 16'h0043);
      @(negedge ref_clk);
      check("irq cleared", 16'h0000, {15'h0, irq});
      gate_case(6'b000001, 5'h1F, 5'h00);
      read_chk(DRIVER_FAULT_STATE_OFS, 16'h0001);
      reg_write(DRIVER_CONFIGURATION_OFS, 16'h0000);
      ot <= 1'b0;
      @(posedge ref_clk);
      ot <= 1'b1;
      repeat (2) @(negedge ref_clk);
      check("irq masked", 16'h0000, {15'h0, irq});
      $display("test alarm done");
      gate_case(6'b101110, 5'h1F, 5'h00);
      reg_write(DRIVER_CONFIGURATION_OFS, 16'h0012);
      repeat (2) @(negedge ref_clk);
      check("boost irq", 16'h0001, {15'h0, irq});
      read_chk(DRIVER_FAULT_STATE_OFS, 16'h0077);
      gate_case(6'b100011, 5'h1F, 5'h1F);
      $display("test boost done");
      give_verdict();
   end
endmodule
